//--- bench/rtcc_sva.sv
// Checker of the counter/compare/status block, sees only top-level ports.
// Assumes the constants header is on the include path; bound below.
`timescale 1ns/1ps
`include "rtcc_consts.svh"
module rtcc_sva (
	// Clock and resets
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic por_in,
	// Bus and interrupt
	input wire logic [5:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic avs_waitrequest_out,
	input wire logic irq_out
);
	logic [31:0] cld_reg;
	logic run_reg;
	wire rd_acc = avs_read_in && !avs_waitrequest_out;
	wire wr_acc = avs_write_in && !avs_waitrequest_out;

	// ==========================================================
	// Shadows of the load value and the run bit
	always_ff @(posedge core_clk_in) begin
		if (reset_in || por_in) begin
			cld_reg <= 32'h0000_0000;
		end else if (wr_acc && avs_address_in == `RTCC_OFF_CLD && avs_byteenable_in == 4'hf) begin
			cld_reg <= avs_writedata_in;
		end
	end
	always_ff @(posedge core_clk_in) begin
		if (reset_in || por_in) begin
			run_reg <= 1'b0;
		end else if (wr_acc && avs_address_in == `RTCC_OFF_CTRL && avs_byteenable_in[0]) begin
			run_reg <= avs_writedata_in[`RTCC_CTRL_RUN_BIT];
		end
	end

	// ==========================================================
	// Accepted accesses
	sequence s_rd(logic [5:0] a);
		rd_acc && avs_address_in == a;
	endsequence
	sequence s_wr(logic [5:0] a);
		wr_acc && avs_address_in == a && avs_byteenable_in[0];
	endsequence
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (reset_in || por_in);

	// ==========================================================
	// Properties
	a_upd_width: assert property (s_rd(`RTCC_OFF_UPD) |-> avs_readdata_out[31:5] == 27'h0)
		else $error("update status has bits above four");
	a_evt_width: assert property (s_rd(`RTCC_OFF_EVT) |-> avs_readdata_out[31:3] == 29'h0)
		else $error("event status has bits above two");
	a_prd_width: assert property (s_rd(`RTCC_OFF_PRD) |-> avs_readdata_out[31:16] == 16'h0)
		else $error("prescaler readback wider than 16 bits");
	a_cmp1_width: assert property (s_rd(`RTCC_OFF_CMP1) |-> avs_readdata_out[31:16] == 16'h0)
		else $error("terminal compare wider than 16 bits");
	a_cld_readback: assert property (s_rd(`RTCC_OFF_CLD) |-> avs_readdata_out == cld_reg)
		else $error("counter load reads back a wrong value");
	a_ien_off: assert property (s_wr(`RTCC_OFF_IEN) ##0 avs_writedata_in[2:0] == 3'h0 |=> !irq_out)
		else $error("interrupt high with all enables off");
	a_evt_clear: assert property (s_wr(`RTCC_OFF_EVT) ##0 (avs_writedata_in[2:0] == 3'h7 && !run_reg)
		|=> !irq_out [*2])
		else $error("interrupt stays after clearing all events");
	a_irq_reset: assert property (disable iff (1'b0) reset_in |=> !irq_out)
		else $error("interrupt high after reset");
	a_wait_once: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> !avs_waitrequest_out)
		else $error("more than one wait cycle");
endmodule
bind rtcc_top rtcc_sva u_sva (.core_clk_in(core_clk_in), .reset_in(reset_in), .por_in(por_in),
	.avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
	.avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
	.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
	.irq_out(irq_out));

//--- bench/rtcc_top_tb_top.sv
// Testbench of the counter/compare/status block through its Avalon-MM port.
// Assumes design sources and checker are compiled first.
`timescale 1ns/1ps
`include "rtcc_consts.svh"
module rtcc_top_tb_top;
	logic core_clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic por_in = 1'b1;
	logic [5:0] addr = 6'h00;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] rdata;
	logic waitreq;
	logic irq;
	logic [31:0] q;
	logic [31:0] c;
	logic [5:0] ta[10];
	logic [31:0] tv[10];
	int failures = 0;
	int checked = 0;
	int cycles = 0;

	rtcc_top u_dut (
		.core_clk_in(core_clk_in),
		.reset_in(reset_in),
		.por_in(por_in),
		.avs_address_in(addr),
		.avs_read_in(rd_en),
		.avs_write_in(wr_en),
		.avs_writedata_in(wdata),
		.avs_byteenable_in(4'hf),
		.avs_readdata_out(rdata),
		.avs_waitrequest_out(waitreq),
		.irq_out(irq)
	);

	initial begin
		forever #12.5 core_clk_in = ~core_clk_in;
	end
	always @(posedge core_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			wrap_up();
		end
	end

	// ==========================================================
	// Bus cycles and comparisons
	task automatic wrap_up();
		$display("Counts: %0d checks, %0d failures", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		addr <= a;
		wdata <= d;
		wr_en <= w;
		rd_en <= !w;
		@(posedge core_clk_in);
		while (waitreq !== 1'b0) begin
			@(posedge core_clk_in);
		end
		q = rdata;
		wr_en <= 1'b0;
		rd_en <= 1'b0;
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0000_0000);
		chk(q, e);
	endtask
	task automatic tab_chk();
		for (int i = 0; i < 10; i++) begin
			rd_chk(ta[i], tv[i]);
		end
	endtask
	task automatic wait_irq();
		for (int i = 0; i < 400 && irq !== 1'b1; i++) begin
			@(negedge core_clk_in);
		end
		chk(32'(irq), 32'h0000_0001);
	endtask

	// ==========================================================
	// Tests
	initial begin
		ta = '{`RTCC_OFF_UPD, `RTCC_OFF_EVT, `RTCC_OFF_IEN, `RTCC_OFF_PRD, `RTCC_OFF_CRD,
			`RTCC_OFF_CLD, `RTCC_OFF_CMP1, `RTCC_OFF_CMP2, `RTCC_OFF_CMP3, 6'h28};
		tv = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_0001, 32'h0, 32'h0000_7fff,
			32'hffff_ffff, 32'hffff_ffff, 32'h0};
		repeat (5) @(posedge core_clk_in);
		reset_in <= 1'b0;
		por_in <= 1'b0;
		tab_chk();
		wr(6'h28, 32'hffff_ffff);
		wr(`RTCC_OFF_PRD, 32'h0000_1234);
		rd_chk(6'h28, 32'h0000_0000);
		rd_chk(`RTCC_OFF_PRD, 32'h0000_0000);
		$display("Test power-on values done");
		wr(`RTCC_OFF_CMP1, 32'h0000_0003);
		wr(`RTCC_OFF_CMP2, 32'h0000_0012);
		wr(`RTCC_OFF_CMP3, 32'hffff_0000);
		wr(`RTCC_OFF_CLD, 32'h0000_0010);
		rd_chk(`RTCC_OFF_UPD, 32'h0000_0002);
		rd_chk(`RTCC_OFF_CLD, 32'h0000_0010);
		wr(`RTCC_OFF_IEN, 32'h0000_0002);
		wr(`RTCC_OFF_CTRL, 32'h0000_0001);
		wait_irq();
		wr(`RTCC_OFF_CTRL, 32'h0000_0000);
		rd_chk(`RTCC_OFF_UPD, 32'h0000_0000);
		rd_chk(`RTCC_OFF_EVT, 32'h0000_0003);
		xfer(1'b0, `RTCC_OFF_CRD, 32'h0000_0000);
		c = q;
		chk(32'(c >= 32'h0000_0012 && c <= 32'h0000_0014), 32'h0000_0001);
		$display("Test load and compare 2 done");
		wr(`RTCC_OFF_EVT, 32'h0000_0002);
		@(negedge core_clk_in);
		chk(32'(irq), 32'h0000_0000);
		wr(`RTCC_OFF_EVT, 32'h0000_0000);
		rd_chk(`RTCC_OFF_EVT, 32'h0000_0001);
		wr(`RTCC_OFF_EVT, 32'h0000_0001);
		rd_chk(`RTCC_OFF_EVT, 32'h0000_0000);
		$display("Test event clearing done");
		wr(`RTCC_OFF_CMP3, c + 32'h0000_0002);
		wr(`RTCC_OFF_IEN, 32'h0000_0004);
		wr(`RTCC_OFF_CTRL, 32'h0000_0001);
		wait_irq();
		wr(`RTCC_OFF_CTRL, 32'h0000_0000);
		rd_chk(`RTCC_OFF_EVT, 32'h0000_0005);
		wr(`RTCC_OFF_IEN, 32'h0000_0000);
		wr(`RTCC_OFF_IEN, 32'h0000_0007);
		@(negedge core_clk_in);
		chk(32'(irq), 32'h0000_0001);
		wr(`RTCC_OFF_EVT, 32'h0000_0007);
		@(negedge core_clk_in);
		chk(32'(irq), 32'h0000_0000);
		$display("Test compare 3 done");
		xfer(1'b0, `RTCC_OFF_CRD, 32'h0000_0000);
		tv[4] = q;
		xfer(1'b0, `RTCC_OFF_PRD, 32'h0000_0000);
		tv[3] = q;
		tv[6] = 32'h0000_0003;
		tv[7] = 32'h0000_0012;
		tv[8] = c + 32'h0000_0002;
		@(posedge core_clk_in);
		reset_in <= 1'b1;
		repeat (5) @(posedge core_clk_in);
		reset_in <= 1'b0;
		tab_chk();
		$display("Test system reset done");
		wrap_up();
	end
endmodule

//--- hdl/rtcc_consts.svh
// Constants of the counter/compare/status block: offsets, fields, resets.
// Assumes byte addresses on a 32-bit Avalon-MM slave, one word per register.
`ifndef RTCC_CONSTS_SVH
`define RTCC_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define RTCC_OFF_CTRL 6'h00
`define RTCC_OFF_UPD 6'h04
`define RTCC_OFF_EVT 6'h08
`define RTCC_OFF_IEN 6'h0c
`define RTCC_OFF_PRD 6'h10
`define RTCC_OFF_CRD 6'h14
`define RTCC_OFF_CLD 6'h18
`define RTCC_OFF_CMP1 6'h1c
`define RTCC_OFF_CMP2 6'h20
`define RTCC_OFF_CMP3 6'h24

// ==========================================================
// Field positions
`define RTCC_CTRL_RUN_BIT 0
`define RTCC_CTRL_DIV_LSB 8
`define RTCC_EVT_BITS 3

// ==========================================================
// Reset values
`define RTCC_RST_BYTE 8'h00
`define RTCC_RST_PRESC 16'h0000
`define RTCC_RST_CNT 32'h0000_0001
`define RTCC_RST_CLD 32'h0000_0000
`define RTCC_RST_CMP1 16'h7fff
`define RTCC_RST_CMP23 32'hffff_ffff
`define RTCC_RST_DIV 5'h00

`endif

//--- hdl/rtcc_divider.sv
// Programmable divider of the core clock, one-cycle tick per period.
// Assumes load_in is a one-cycle pulse on the core clock.
`timescale 1ns/1ps
`include "rtcc_consts.svh"
module rtcc_divider #(
	parameter int DIV_W = 5
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// Divisor update
	input wire logic [DIV_W-1:0] divisor_in,
	input wire logic load_in,
	// Results
	output logic tick_out,
	output logic pending_out
);
	logic [DIV_W-1:0] count_reg;
	logic [DIV_W-1:0] active_reg;
	logic [DIV_W-1:0] shadow_reg;
	logic wrap;

	initial begin
		if (DIV_W < 1 || DIV_W > 16) $error("rtcc_divider: DIV_W out of range");
	end

	assign wrap = (count_reg == active_reg);
	assign tick_out = wrap;

	always_ff @(posedge core_clk_in) begin
		if (rst_in || wrap) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_reg + 1'b1;
		end
	end

	// New divisor is taken only at a period boundary
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			active_reg <= DIV_W'(`RTCC_RST_DIV);
			shadow_reg <= DIV_W'(`RTCC_RST_DIV);
			pending_out <= 1'b0;
		end else begin
			if (load_in) begin
				shadow_reg <= divisor_in;
			end
			if (wrap && pending_out) begin
				active_reg <= shadow_reg;
			end
			pending_out <= load_in | (pending_out & ~wrap);
		end
	end
endmodule

//--- hdl/rtcc_event_status.sv
// Sticky event bits with write-one-to-clear, enable mask and one interrupt.
// Assumes set and clear are one-cycle pulses on the core clock.
`timescale 1ns/1ps
module rtcc_event_status #(
	parameter int BITS = 3
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// Events and software access
	input wire logic [BITS-1:0] set_in,
	input wire logic [BITS-1:0] clear_in,
	input wire logic [BITS-1:0] enable_in,
	// Results
	output logic [BITS-1:0] status_out,
	output logic irq_out
);
	initial begin
		if (BITS < 1 || BITS > 8) $error("rtcc_event_status: BITS out of range");
	end

	genvar i;
	generate
		for (i = 0; i < BITS; i++) begin : g_bit
			// A new event beats a clear in the same cycle
			always_ff @(posedge core_clk_in) begin
				if (rst_in) begin
					status_out[i] <= 1'b0;
				end else if (set_in[i]) begin
					status_out[i] <= 1'b1;
				end else if (clear_in[i]) begin
					status_out[i] <= 1'b0;
				end
			end
		end
	endgenerate

	assign irq_out = |(status_out & enable_in);
endmodule

//--- hdl/rtcc_pkg.sv
// Types shared by the counter/compare/status block.
// Assumes the constants header is compiled alongside.
package rtcc_pkg;

	// ==========================================================
	// Control word written by software
	typedef struct packed {
		logic [4:0] divisor;
		logic run;
	} rtcc_ctrl_t;

	// ==========================================================
	// Pending update flags, high bit first
	typedef struct packed {
		logic compare3_pending;
		logic compare2_pending;
		logic compare1_pending;
		logic counter_load_pending;
		logic divisor_pending;
	} rtcc_pending_t;

endpackage

//--- hdl/rtcc_top.sv
// Counter, compare and status block of a real-time clock, Avalon-MM slave.
// Assumes one 40 MHz core clock; por_in and reset_in are synchronous.
// Function
// - read-only update status, low five bits, cleared
// - divisor pending until divider takes it
// - counter load applied at prescaler output edge
// - load sets pending, cleared on transfer
// - load register reads back, resets zero
// - compare 1 write pending until effective
// - prescaler match clears prescaler, sets event 1
// - compare 2 write pending until effective
// - compare 3 write pending until effective
// - counter matches set events 2 and 3
// - event status bits 0-2, reset clears
// - write one clears event, zero keeps
// - interrupt only for enabled events, enables reset
// - live prescaler readback, only power-on clears
// - live counter readback, power-on sets one
// - compares survive system reset, power-on defaults
`timescale 1ns/1ps
`include "rtcc_consts.svh"
module rtcc_top #(
	parameter int PRESC_W = 16,
	parameter int CNT_W = 32,
	parameter int DIV_W = 5
) (
	// Clock and resets
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic por_in,
	// Avalon-MM slave
	input wire logic [5:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// Interrupt
	output logic irq_out
);

	// ==========================================================
	// Parameter check
	initial begin
		if (PRESC_W != 16 || CNT_W != 32 || DIV_W != 5) begin
			$error("rtcc_top: only 16-bit prescaler, 32-bit counter, 5-bit divider");
		end
	end

	// ==========================================================
	// Helpers
	function automatic logic hit(input logic [5:0] addr, input logic [5:0] off);
		hit = (addr[5:2] == off[5:2]);
	endfunction

	function automatic logic [31:0] be_merge(
		input logic [31:0] old_val,
		input logic [31:0] new_val,
		input logic [3:0] be
	);
		logic [31:0] res;
		res = old_val;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[8*b +: 8] = new_val[8*b +: 8];
			end
		end
		be_merge = res;
	endfunction

	// ==========================================================
	// Declarations
	logic any_rst;
	logic ack_reg;
	logic req;
	logic wr_fire;
	logic [31:0] rdata_next;
	rtcc_pkg::rtcc_ctrl_t ctrl_reg;
	rtcc_pkg::rtcc_pending_t pend;
	logic div_load;
	logic div_pending;
	logic tick;
	logic presc_step;
	logic presc_wrap;
	logic [15:0] presc_reg;
	logic [31:0] count_reg;
	logic [31:0] count_next;
	logic [31:0] load_reg;
	logic load_pending_reg;
	logic [15:0] cmp1_reg;
	logic [15:0] cmp1_act_reg;
	logic cmp1_pending_reg;
	logic [31:0] cmp2_reg;
	logic [31:0] cmp2_act_reg;
	logic cmp2_pending_reg;
	logic [31:0] cmp3_reg;
	logic [31:0] cmp3_act_reg;
	logic cmp3_pending_reg;
	logic [7:0] ien_reg;
	logic [2:0] evt_set;
	logic [2:0] evt_clear;
	logic [2:0] evt_status;
	logic wr_ctrl;
	logic wr_evt;
	logic wr_ien;
	logic wr_cld;
	logic wr_cmp1;
	logic wr_cmp2;
	logic wr_cmp3;
	logic [31:0] cmp1_word;
	logic [31:0] cmp1_merge;
	logic [31:0] ctrl_word;

	assign any_rst = reset_in | por_in;

	// ==========================================================
	// Bus handshake: one wait cycle on every access
	assign req = avs_read_in | avs_write_in;
	assign avs_waitrequest_out = req & ~ack_reg;
	assign wr_fire = avs_write_in & ack_reg;

	always_ff @(posedge core_clk_in) begin
		if (any_rst) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req & ~ack_reg;
		end
	end

	// ==========================================================
	// Write decode
	assign wr_ctrl = wr_fire & hit(avs_address_in, `RTCC_OFF_CTRL);
	assign wr_evt = wr_fire & hit(avs_address_in, `RTCC_OFF_EVT);
	assign wr_ien = wr_fire & hit(avs_address_in, `RTCC_OFF_IEN);
	assign wr_cld = wr_fire & hit(avs_address_in, `RTCC_OFF_CLD);
	assign wr_cmp1 = wr_fire & hit(avs_address_in, `RTCC_OFF_CMP1);
	assign wr_cmp2 = wr_fire & hit(avs_address_in, `RTCC_OFF_CMP2);
	assign wr_cmp3 = wr_fire & hit(avs_address_in, `RTCC_OFF_CMP3);

	assign ctrl_word = {19'h0_0000, ctrl_reg.divisor, 7'h00, ctrl_reg.run};
	assign cmp1_word = {16'h0000, cmp1_reg};
	assign cmp1_merge = be_merge(cmp1_word, avs_writedata_in, avs_byteenable_in);

	// ==========================================================
	// Control register: run bit and divisor
	always_ff @(posedge core_clk_in) begin
		if (any_rst) begin
			ctrl_reg.run <= 1'b0;
			ctrl_reg.divisor <= `RTCC_RST_DIV;
		end else if (wr_ctrl) begin
			if (avs_byteenable_in[0]) begin
				ctrl_reg.run <= avs_writedata_in[`RTCC_CTRL_RUN_BIT];
			end
			if (avs_byteenable_in[1]) begin
				ctrl_reg.divisor <= avs_writedata_in[`RTCC_CTRL_DIV_LSB +: 5];
			end
		end
	end

	assign div_load = wr_ctrl & avs_byteenable_in[1];

	rtcc_divider #(
		.DIV_W(DIV_W)
	) u_divider (
		.core_clk_in(core_clk_in),
		.rst_in(any_rst),
		.divisor_in(avs_writedata_in[`RTCC_CTRL_DIV_LSB +: 5]),
		.load_in(div_load),
		.tick_out(tick),
		.pending_out(div_pending)
	);

	// ==========================================================
	// Prescaler
	assign presc_step = tick & ctrl_reg.run;
	assign presc_wrap = presc_step & (presc_reg == cmp1_act_reg);

	always_ff @(posedge core_clk_in) begin
		if (por_in) begin
			presc_reg <= `RTCC_RST_PRESC;
		end else if (presc_wrap) begin
			presc_reg <= '0;
		end else if (presc_step) begin
			presc_reg <= presc_reg + 1'b1;
		end
	end

	// ==========================================================
	// Counter
	always_comb begin
		if (load_pending_reg) begin
			count_next = load_reg;
		end else begin
			count_next = count_reg + 32'h0000_0001;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (por_in) begin
			count_reg <= `RTCC_RST_CNT;
		end else if (presc_wrap) begin
			count_reg <= count_next;
		end
	end

	// ==========================================================
	// Counter load register and its pending flag
	always_ff @(posedge core_clk_in) begin
		if (any_rst) begin
			load_reg <= `RTCC_RST_CLD;
		end else if (wr_cld) begin
			load_reg <= be_merge(load_reg, avs_writedata_in, avs_byteenable_in);
		end
	end

	// A write landing on the transfer edge keeps the flag for the next one
	always_ff @(posedge core_clk_in) begin
		if (any_rst) begin
			load_pending_reg <= 1'b0;
		end else if (wr_cld) begin
			load_pending_reg <= 1'b1;
		end else if (presc_wrap) begin
			load_pending_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Compare 1: prescaler terminal count
	always_ff @(posedge core_clk_in) begin
		if (por_in) begin
			cmp1_reg <= `RTCC_RST_CMP1;
		end else if (wr_cmp1) begin
			cmp1_reg <= cmp1_merge[15:0];
		end
	end

	// System reset drops pending flags, so the active copy catches up then
	always_ff @(posedge core_clk_in) begin
		if (por_in) begin
			cmp1_act_reg <= `RTCC_RST_CMP1;
		end else if (reset_in || (tick && cmp1_pending_reg)) begin
			cmp1_act_reg <= cmp1_reg;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (any_rst) begin
			cmp1_pending_reg <= 1'b0;
		end else if (wr_cmp1) begin
			cmp1_pending_reg <= 1'b1;
		end else if (tick) begin
			cmp1_pending_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Compare 2
	always_ff @(posedge core_clk_in) begin
		if (por_in) begin
			cmp2_reg <= `RTCC_RST_CMP23;
		end else if (wr_cmp2) begin
			cmp2_reg <= be_merge(cmp2_reg, avs_writedata_in, avs_byteenable_in);
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (por_in) begin
			cmp2_act_reg <= `RTCC_RST_CMP23;
		end else if (reset_in || (tick && cmp2_pending_reg)) begin
			cmp2_act_reg <= cmp2_reg;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (any_rst) begin
			cmp2_pending_reg <= 1'b0;
		end else if (wr_cmp2) begin
			cmp2_pending_reg <= 1'b1;
		end else if (tick) begin
			cmp2_pending_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Compare 3
	always_ff @(posedge core_clk_in) begin
		if (por_in) begin
			cmp3_reg <= `RTCC_RST_CMP23;
		end else if (wr_cmp3) begin
			cmp3_reg <= be_merge(cmp3_reg, avs_writedata_in, avs_byteenable_in);
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (por_in) begin
			cmp3_act_reg <= `RTCC_RST_CMP23;
		end else if (reset_in || (tick && cmp3_pending_reg)) begin
			cmp3_act_reg <= cmp3_reg;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (any_rst) begin
			cmp3_pending_reg <= 1'b0;
		end else if (wr_cmp3) begin
			cmp3_pending_reg <= 1'b1;
		end else if (tick) begin
			cmp3_pending_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Update status
	assign pend.divisor_pending = div_pending;
	assign pend.counter_load_pending = load_pending_reg;
	assign pend.compare1_pending = cmp1_pending_reg;
	assign pend.compare2_pending = cmp2_pending_reg;
	assign pend.compare3_pending = cmp3_pending_reg;

	// ==========================================================
	// Events: compare 2 and 3 fire when the counter takes the matching value
	assign evt_set[0] = presc_wrap;
	assign evt_set[1] = presc_wrap & (count_next == cmp2_act_reg);
	assign evt_set[2] = presc_wrap & (count_next == cmp3_act_reg);
	assign evt_clear = wr_evt & avs_byteenable_in[0] ? avs_writedata_in[2:0] : 3'b000;

	always_ff @(posedge core_clk_in) begin
		if (any_rst) begin
			ien_reg <= `RTCC_RST_BYTE;
		end else if (wr_ien && avs_byteenable_in[0]) begin
			ien_reg <= {5'b0_0000, avs_writedata_in[2:0]};
		end
	end

	rtcc_event_status #(
		.BITS(`RTCC_EVT_BITS)
	) u_events (
		.core_clk_in(core_clk_in),
		.rst_in(any_rst),
		.set_in(evt_set),
		.clear_in(evt_clear),
		.enable_in(ien_reg[2:0]),
		.status_out(evt_status),
		.irq_out(irq_out)
	);

	// ==========================================================
	// Read path: data captured in the wait cycle, stands when wait drops
	always_comb begin
		rdata_next = 32'h0000_0000;
		if (hit(avs_address_in, `RTCC_OFF_CTRL)) begin
			rdata_next = ctrl_word;
		end else if (hit(avs_address_in, `RTCC_OFF_UPD)) begin
			rdata_next = {27'h000_0000, pend};
		end else if (hit(avs_address_in, `RTCC_OFF_EVT)) begin
			rdata_next = {29'h0000_0000, evt_status};
		end else if (hit(avs_address_in, `RTCC_OFF_IEN)) begin
			rdata_next = {24'h00_0000, ien_reg};
		end else if (hit(avs_address_in, `RTCC_OFF_PRD)) begin
			rdata_next = {16'h0000, presc_reg};
		end else if (hit(avs_address_in, `RTCC_OFF_CRD)) begin
			rdata_next = count_reg;
		end else if (hit(avs_address_in, `RTCC_OFF_CLD)) begin
			rdata_next = load_reg;
		end else if (hit(avs_address_in, `RTCC_OFF_CMP1)) begin
			rdata_next = cmp1_word;
		end else if (hit(avs_address_in, `RTCC_OFF_CMP2)) begin
			rdata_next = cmp2_reg;
		end else if (hit(avs_address_in, `RTCC_OFF_CMP3)) begin
			rdata_next = cmp3_reg;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (any_rst) begin
			avs_readdata_out <= 32'h0000_0000;
		end else if (avs_read_in && !ack_reg) begin
			avs_readdata_out <= rdata_next;
		end
	end

endmodule
